// file: rtl/scc_consts.svh
// Purpose: constants of the serial configuration control block
// Assumes: 32-bit AHB-Lite, byte addresses, one word per register
// Notes: timing counts derive from the clock period
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH
`define SCC_CLK_NS      10
`define SCC_HALF_NS     40
`define SCC_HALF_CYC    ((`SCC_HALF_NS) / (`SCC_CLK_NS))
`define SCC_OFF_CFG     32'h0000_7040
`define SCC_OFF_CTL     32'h0000_7044
`define SCC_OFF_DAT     32'h0000_7048
`define SCC_OFF_RXH     32'h0000_704c
`define SCC_OFF_STS     32'h0000_7050
`define SCC_OFF_CLR     32'h0000_7054
`define SCC_OFF_IEN     32'h0000_7058
`define SCC_CFG_SRST    7
`define SCC_CFG_POL     6
`define SCC_CFG_LOOP    4
`define SCC_CTL_PHASE   0
`define SCC_CTL_MASTER  1
`define SCC_CTL_TALK    2
`define SCC_CTL_LOOP    3
`define SCC_STS_DONE    0
`define SCC_STS_LOST    1
`define SCC_STS_FULL    2
`define SCC_STS_BUSY    3
`define SCC_CFG_RST     8'h00
`define SCC_CTL_RST     4'h0
`endif

// file: rtl/scc_pkg.sv
// Purpose: types of the serial configuration control block
// Assumes: nothing beyond the constants header
// Notes: the whole block state is one packed struct
package scc_pkg;
    typedef enum logic [0:0] {
        SCC_IDLE  = 1'b0,
        SCC_SHIFT = 1'b1
    } scc_fsm_t;

    typedef struct packed {
        logic clk;
        logic mo;
        logic mi;
    } scc_pin_in_t;

    typedef struct packed {
        logic clk_o;
        logic clk_oe;
        logic mo_o;
        logic mo_oe;
        logic mi_o;
        logic mi_oe;
    } scc_pin_out_t;

    typedef struct packed {
        logic        cfg_srst_n;
        logic        cfg_pol;
        logic [3:0]  cfg_len;
        logic        ctl_phase;
        logic        ctl_master;
        logic        ctl_talk;
        logic        ctl_loop;
        logic [1:0]  irq_en;
        logic [1:0]  sts;
        logic        tx_full;
        logic [15:0] tx_hold;
        logic [15:0] rx_hold;
        logic [15:0] shreg;
        logic [4:0]  cnt;
        logic [7:0]  div;
        logic        clk_lvl;
        logic        out_bit;
        scc_fsm_t    fsm;
        logic        a_wr;
        logic [31:0] a_addr;
        logic [31:0] hrdata;
        logic        clk_s1;
        logic        clk_s2;
        logic        clk_s3;
        logic        mo_s1;
        logic        mo_s2;
        logic        mi_s1;
        logic        mi_s2;
    } scc_state_t;
endpackage

// file: rtl/scc_top.sv
// Purpose: serial configuration control with shift engine and AHB-Lite registers
// Assumes: single word transfers, zero wait states, response always OKAY
// Notes: pin inputs pass two flip-flops before use
// Functional notes
// (R1) soft reset low clears overrun, character done and transmit occupied flags and returns the shift engine to idle
// (R2) master: soft reset low returns shift clock to its idle level
// (R3) character written during soft reset is never shifted out
// (R4) polarity 0: shift clock idles low
// (R5) polarity 0 phase 0: drive on rising, sample on falling edge
// (R6) polarity 0 phase 1: first bit early, then falling drive, rising sample
// (R7) polarity 1: shift clock idles high
// (R8) polarity 1 phase 0: drive on falling, sample on rising edge
// (R9) polarity 1 phase 1: first bit early, then rising drive, falling sample
// (R10) loopback joins master out to master in, master only, off after reset
// (R11) character length is field value plus one, 1 to 16 bits
// (R12) reserved configuration bit reads zero, writes ignored
// (R13) software clears soft reset before reconfiguring, sets it to resume
// (R14) phase 1: first bit presented after data write, before first edge
// (R15) short received characters sit right-justified in the receive holding register
// (R16) configuration writes touch only soft reset, polarity and length
`include "scc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module scc_top
    import scc_pkg::*;
(
    // clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // ahb-lite slave
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic [31:0]       hrdata,
    output logic              hresp,
    // serial pins
    input  wire scc_pin_in_t  pins_i,
    output scc_pin_out_t      pins_o,
    // interrupt
    output logic              irq
);
    scc_state_t st;
    scc_state_t nx;

    logic       acc;
    logic       div_hit;
    logic       m_tick;
    logic       s_edge;
    logic       lead;
    logic       trail;
    logic       drive;
    logic       samp;
    logic [4:0] len1;
    logic [4:0] cnt_nx;
    logic       top;
    logic       hold_top;
    logic       in_bit;
    logic       done;
    logic       load;

    function automatic logic [31:0] rd_mux(input logic [31:0] a, input scc_state_t s);
        logic [31:0] d;
        d = 32'h0000_0000;
        unique case (a)
            `SCC_OFF_CFG: d[7:0] = {s.cfg_srst_n, s.cfg_pol, 1'b0, s.ctl_loop, s.cfg_len}; // R12
            `SCC_OFF_CTL: d[3:0] = {s.ctl_loop, s.ctl_talk, s.ctl_master, s.ctl_phase};
            `SCC_OFF_DAT: d[15:0] = s.tx_hold;
            `SCC_OFF_RXH: d[15:0] = s.rx_hold; // R15
            `SCC_OFF_STS: d[3:0] = {s.fsm == SCC_SHIFT, s.tx_full, s.sts};
            `SCC_OFF_IEN: d[1:0] = s.irq_en;
            default:      d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    assign acc      = hsel && htrans[1] && hready;
    // master divider: one half shift-clock period per tick
    assign div_hit  = st.div == 8'(`SCC_HALF_CYC - 1);
    assign m_tick   = st.fsm == SCC_SHIFT && st.ctl_master && div_hit;
    assign s_edge   = st.fsm == SCC_SHIFT && !st.ctl_master && (st.clk_s2 != st.clk_s3);
    // leading edge leaves the idle level, trailing edge returns to it
    assign lead     = m_tick ? (st.clk_lvl == st.cfg_pol) : (s_edge && st.clk_s3 == st.cfg_pol);
    assign trail    = m_tick ? (st.clk_lvl != st.cfg_pol) : (s_edge && st.clk_s2 == st.cfg_pol);
    assign drive    = st.ctl_phase ? trail : lead; // R5 R6 R8 R9
    assign samp     = st.ctl_phase ? lead : trail; // R5 R6 R8 R9
    assign len1     = {1'b0, st.cfg_len} + 5'd1; // R11
    assign cnt_nx   = samp ? st.cnt + 5'd1 : st.cnt;
    assign top      = st.shreg[st.cfg_len];
    assign hold_top = st.tx_hold[st.cfg_len];
    assign in_bit   = st.ctl_master ? (st.ctl_loop ? st.out_bit : st.mi_s2) : st.mo_s2; // R10
    assign done     = trail && cnt_nx == len1; // R11
    // slave reloads only between characters and never on a clock edge
    assign load     = st.tx_full && st.cfg_srst_n
                      && (st.ctl_master ? st.fsm == SCC_IDLE : (st.cnt == 5'd0 && !s_edge));

    always_comb begin
        logic [1:0] clr;
        logic [1:0] ev;
        clr = 2'b00;
        ev  = 2'b00;
        nx  = st;
        nx.clk_s1 = pins_i.clk;
        nx.clk_s2 = st.clk_s1;
        nx.clk_s3 = st.clk_s2;
        nx.mo_s1  = pins_i.mo;
        nx.mo_s2  = st.mo_s1;
        nx.mi_s1  = pins_i.mi;
        nx.mi_s2  = st.mi_s1;
        nx.a_wr   = acc && hwrite && hsize == 3'b010;
        if (acc) begin
            nx.a_addr = haddr;
        end
        if (acc && !hwrite) begin
            nx.hrdata = rd_mux(haddr, st);
        end
        // shift engine
        if (drive) begin
            nx.out_bit = top; // R5 R8
        end
        if (samp) begin
            nx.shreg = {st.shreg[14:0], in_bit};
            nx.cnt   = cnt_nx;
        end
        if (m_tick) begin
            nx.clk_lvl = ~st.clk_lvl;
            nx.div     = 8'h00;
        end else if (st.fsm == SCC_SHIFT && st.ctl_master) begin
            nx.div = st.div + 8'h01;
        end
        if (done) begin
            nx.fsm     = SCC_IDLE;
            nx.cnt     = 5'd0;
            nx.rx_hold = nx.shreg; // R15
            ev[`SCC_STS_DONE] = 1'b1;
            ev[`SCC_STS_LOST] = st.sts[`SCC_STS_DONE];
        end
        if (st.fsm == SCC_IDLE && st.cfg_srst_n && (st.tx_full || !st.ctl_master)) begin
            nx.fsm = SCC_SHIFT;
            nx.div = 8'h00;
        end
        if (load) begin
            nx.shreg   = st.tx_hold;
            nx.tx_full = 1'b0;
            nx.cnt     = 5'd0;
            if (st.ctl_phase) begin
                nx.out_bit = hold_top; // R14 R6 R9
            end
        end
        // register writes, data phase
        if (st.a_wr) begin
            unique case (st.a_addr)
                `SCC_OFF_CFG: begin
                    nx.cfg_srst_n = hwdata[`SCC_CFG_SRST]; // R16
                    nx.cfg_pol    = hwdata[`SCC_CFG_POL]; // R16
                    nx.cfg_len    = hwdata[3:0]; // R16 R12
                end
                `SCC_OFF_CTL: begin
                    nx.ctl_phase  = hwdata[`SCC_CTL_PHASE];
                    nx.ctl_master = hwdata[`SCC_CTL_MASTER];
                    nx.ctl_talk   = hwdata[`SCC_CTL_TALK];
                    nx.ctl_loop   = hwdata[`SCC_CTL_LOOP];
                end
                `SCC_OFF_DAT: begin
                    nx.tx_hold = hwdata[15:0];
                    nx.tx_full = st.cfg_srst_n; // R3
                end
                `SCC_OFF_CLR: clr = hwdata[1:0];
                `SCC_OFF_IEN: nx.irq_en = hwdata[1:0];
                default: ;
            endcase
        end
        // set wins over a clear in the same cycle
        nx.sts = (st.sts & ~clr) | ev;
        if (!st.cfg_srst_n) begin
            nx.sts     = 2'b00; // R1
            nx.tx_full = 1'b0; // R1 R3
            nx.fsm     = SCC_IDLE;
            nx.cnt     = 5'd0;
            nx.div     = 8'h00;
        end
        if (nx.fsm == SCC_IDLE) begin
            nx.clk_lvl = nx.cfg_pol; // R2 R4 R7
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0; // R10
        end else begin
            st <= nx;
        end
    end

    assign hreadyout     = 1'b1;
    assign hresp         = 1'b0;
    assign hrdata        = st.hrdata;
    assign irq           = |(st.sts & st.irq_en);
    // slave never drives the clock; talk gates only the data line
    assign pins_o.clk_o  = st.clk_lvl;
    assign pins_o.clk_oe = st.ctl_master;
    assign pins_o.mo_o   = st.out_bit;
    assign pins_o.mo_oe  = st.ctl_master && st.ctl_talk;
    assign pins_o.mi_o   = st.out_bit;
    assign pins_o.mi_oe  = !st.ctl_master && st.ctl_talk;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_dat_write;
        st.a_wr && st.a_addr == `SCC_OFF_DAT;
    endsequence

    sequence s_cfg_write;
        st.a_wr && st.a_addr == `SCC_OFF_CFG;
    endsequence

    sequence s_cfg_read;
        acc && !hwrite && haddr == `SCC_OFF_CFG;
    endsequence

    a_srst_flags: assert property ( // R1
        !st.cfg_srst_n |=> st.sts == 2'b00 && !st.tx_full && st.fsm == SCC_IDLE)
        else $error("soft reset left a flag set");

    a_srst_clk_idle: assert property ( // R2
        !st.cfg_srst_n && st.ctl_master |=> pins_o.clk_o == st.cfg_pol)
        else $error("shift clock not idle under soft reset");

    a_stale_tx: assert property ( // R3
        (s_dat_write ##0 !st.cfg_srst_n) |=> !st.tx_full ##1 st.fsm == SCC_IDLE)
        else $error("character written in soft reset was queued");

    a_idle_low: assert property ( // R4
        st.fsm == SCC_IDLE && !st.cfg_pol |-> !pins_o.clk_o)
        else $error("shift clock not low while idle");

    a_idle_high: assert property ( // R7
        st.fsm == SCC_IDLE && st.cfg_pol |-> pins_o.clk_o)
        else $error("shift clock not high while idle");

    a_ph0_drive: assert property ( // R5
        m_tick && st.cfg_srst_n && !st.ctl_phase && lead
            |=> st.out_bit == $past(top) && pins_o.clk_o != st.cfg_pol)
        else $error("phase 0 data not driven on leading edge");

    a_ph1_first: assert property ( // R14
        load && st.ctl_phase |=> st.out_bit == $past(hold_top) && pins_o.clk_o == st.cfg_pol)
        else $error("phase 1 first bit not presented before first edge");

    a_loop_path: assert property ( // R10
        st.ctl_master && st.ctl_loop && samp |=> st.shreg[0] == $past(st.out_bit))
        else $error("loopback did not return the driven bit");

    a_rsvd_zero: assert property ( // R12
        s_cfg_read |=> hrdata[5] == 1'b0 && hrdata[31:8] == 24'h00_0000)
        else $error("reserved configuration bit read nonzero");

    a_cfg_write: assert property ( // R16
        s_cfg_write |=> st.cfg_pol == $past(hwdata[6]) && st.ctl_loop == $past(st.ctl_loop)
            && st.cfg_len == $past(hwdata[3:0]))
        else $error("configuration write touched the wrong fields");

    a_len_done: assert property ( // R11
        done && st.cfg_srst_n |=> st.fsm == SCC_IDLE && st.sts[`SCC_STS_DONE] && st.cnt == 5'd0)
        else $error("character end not flagged");
endmodule

`default_nettype wire

// file: verification/scc_slave_model.sv
// Purpose: remote serial slave on the far side of the block in master mode
// Assumes: polarity, phase, length and word settle one cycle before load
// Notes: after its last bit the line shows the inverse, not a held value
`timescale 1ns/1ps
`default_nettype none
module scc_slave_model (
    // serial lines
    input  wire logic        sclk,
    input  wire logic        mo,
    output logic             mi,
    // setup
    input  wire logic        load,
    input  wire logic        pol,
    input  wire logic        pha,
    input  wire logic [3:0]  len,
    input  wire logic [15:0] word,
    // capture
    output logic [15:0]      got,
    output logic [4:0]       nsamp
);
    int   idx;
    logic lead;
    initial mi = 1'b0;
    always @(sclk or posedge load) begin
        if (load) begin
            got = 16'h0;
            nsamp = 5'd0;
            idx = int'(len);
            if (pha) begin
                mi = word[idx];
                idx--;
            end
        end else begin
            lead = (sclk != pol);
            if (lead == pha) begin
                got = {got[14:0], mo};
                nsamp++;
                if (idx < 0) mi = ~mi;
            end else if (idx >= 0) begin
                mi = word[idx];
                idx--;
            end else mi = ~mi;
        end
    end
endmodule
`default_nettype wire

// file: verification/spi_config_control_tb.sv
// Purpose: self-checking bench for the serial configuration control block
// Assumes: zero-wait slave, one word a transfer
// Notes: slave-mode frame is timed by delays, unrelated to hclk
`include "scc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module spi_config_control_tb
    import scc_pkg::*;
;
    logic         hclk = 1'b0;
    logic         hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    logic [31:0]  haddr, hwdata, hrdata, rd, msk;
    scc_pin_in_t  pins_i;
    scc_pin_out_t pins_o;
    logic         tb_clk, tb_mo, m_load, m_pol, m_pha, m_mi, pol, pha;
    logic [3:0]   m_len, len;
    logic [15:0]  m_word, m_got, tx;
    logic [4:0]   m_n;
    int           errors, checks;
    // polarity, phase, length, word
    localparam logic [21:0] ROWS [4] = '{{2'b00, 4'h7, 16'h00a5}, {2'b01, 4'hf, 16'h1234},
                                         {2'b10, 4'h0, 16'h0001}, {2'b11, 4'h4, 16'h0016}};
    assign hready = hreadyout;
    assign pins_i = {pins_o.clk_oe ? pins_o.clk_o : tb_clk, pins_o.mo_oe ? pins_o.mo_o : tb_mo,
                     pins_o.mi_oe ? pins_o.mi_o : m_mi};
    always #5 hclk = ~hclk;
    scc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pins_i(pins_i),
        .pins_o(pins_o), .irq(irq));
    scc_slave_model u_far (.sclk(pins_o.clk_o), .mo(pins_o.mo_o), .mi(m_mi), .load(m_load),
        .pol(m_pol), .pha(m_pha), .len(m_len), .word(m_word), .got(m_got), .nsamp(m_n));
    task summarize;
        if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'b10; hsize <= 3'b010;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00; hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rdr(input logic [31:0] a);
        xfer(1'b0, a, 32'h0);
    endtask
    task wait_done;
        int i;
        rdr(`SCC_OFF_STS);
        for (i = 0; i < 300 && rd[0] !== 1'b1; i++) rdr(`SCC_OFF_STS);
    endtask
    function automatic logic [31:0] cfgv(input logic s, input logic p, input logic [3:0] l);
        return {24'h0, s, p, 2'b00, l};
    endfunction
    initial begin
        #600000;
        errors++;
        summarize();
    end
    initial begin
        hresetn = 0; hsel = 0; hwrite = 0; htrans = 0; hsize = 0; haddr = 0; hwdata = 0;
        tb_clk = 0; tb_mo = 0; m_load = 0; m_pol = 0; m_pha = 0; m_len = 0; m_word = 0;
        repeat (19) @(posedge hclk);
        chk("irq_rst", 32'h0, {31'h0, irq});
        chk("clk_oe_rst", 32'h0, {31'h0, pins_o.clk_oe});
        @(posedge hclk);
        hresetn <= 1'b1;
        rdr(`SCC_OFF_CFG);
        chk("cfg_rst", 32'h0, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
        for (int r = 0; r < 4; r++) begin
            {pol, pha, len, tx} = ROWS[r];
            msk = (32'h1 << (len + 5'd1)) - 32'h1;
            wr(`SCC_OFF_CFG, cfgv(1'b0, pol, len));
            wr(`SCC_OFF_CTL, {28'h0, 3'b011, pha});
            m_pol <= pol; m_pha <= pha; m_len <= len; m_word <= ~tx;
            @(posedge hclk);
            m_load <= 1'b1;
            @(posedge hclk);
            m_load <= 1'b0;
            wr(`SCC_OFF_CFG, cfgv(1'b1, pol, len));
            wr(`SCC_OFF_DAT, {16'h0, tx});
            if (pha) begin
                repeat (3) @(posedge hclk);
                chk("first_bit", {31'h0, tx[len]}, {31'h0, pins_o.mo_o});
                chk("pre_edge", {31'h0, pol}, {31'h0, pins_o.clk_o});
            end
            wait_done();
            chk("status", 32'h1, rd);
            rdr(`SCC_OFF_RXH);
            chk("rx", {16'h0, ~tx} & msk, rd & msk);
            chk("far_rx", {16'h0, tx} & msk, {16'h0, m_got} & msk);
            chk("bits", {27'h0, len + 5'd1}, {27'h0, m_n});
            chk("idle_clk", {31'h0, pol}, {31'h0, pins_o.clk_o});
            rdr(`SCC_OFF_CFG);
            chk("cfg", cfgv(1'b1, pol, len), rd);
            if (r == 0) begin
                wr(`SCC_OFF_IEN, 32'h1);
                @(posedge hclk);
                chk("irq_on", 32'h1, {31'h0, irq});
                wr(`SCC_OFF_IEN, 32'h0);
                @(posedge hclk);
                chk("irq_mask", 32'h0, {31'h0, irq});
                wr(`SCC_OFF_IEN, 32'h1);
                wr(`SCC_OFF_CLR, 32'h1);
                @(posedge hclk);
                chk("irq_clr", 32'h0, {31'h0, irq});
            end
            if (r != 3) wr(`SCC_OFF_CLR, 32'h3);
        end
        // abort mid-character after soft reset has cleared done
        wr(`SCC_OFF_CFG, cfgv(1'b0, 1'b1, 4'hf));
        wr(`SCC_OFF_CFG, cfgv(1'b1, 1'b1, 4'hf));
        wr(`SCC_OFF_DAT, 32'h5555);
        repeat (40) @(posedge hclk);
        wr(`SCC_OFF_CFG, cfgv(1'b0, 1'b1, 4'hf));
        repeat (2) @(posedge hclk);
        chk("abort_clk", 32'h1, {31'h0, pins_o.clk_o});
        rdr(`SCC_OFF_STS);
        chk("abort_sts", 32'h0, rd);
        rdr(`SCC_OFF_CTL);
        chk("abort_ctl", 32'h7, rd);
        wr(`SCC_OFF_DAT, 32'h00ff);
        wr(`SCC_OFF_CFG, cfgv(1'b1, 1'b0, 4'h7));
        repeat (150) @(posedge hclk);
        rdr(`SCC_OFF_STS);
        chk("stale_tx", 32'h0, rd);
        wr(`SCC_OFF_CTL, 32'he);
        rdr(`SCC_OFF_CFG);
        chk("loop_cfg", cfgv(1'b1, 1'b0, 4'h7) | 32'h10, rd);
        wr(`SCC_OFF_DAT, 32'h003c);
        wait_done();
        rdr(`SCC_OFF_RXH);
        chk("loop_rx", 32'h3c, rd & 32'hff);
        // second character while done still set raises the lost flag
        wr(`SCC_OFF_DAT, 32'h003c);
        repeat (100) @(posedge hclk);
        rdr(`SCC_OFF_STS);
        chk("lost", 32'h3, rd);
        wr(`SCC_OFF_CLR, 32'h3);
        wr(`SCC_OFF_CFG, 32'hff);
        rdr(`SCC_OFF_CFG);
        chk("cfg_rsvd", 32'hdf, rd);
        wr(32'h7060, 32'hffffffff);
        rdr(32'h7060);
        chk("unmapped", 32'h0, rd);
        // slave frame, link clock from the bench at 80 ns
        wr(`SCC_OFF_CFG, cfgv(1'b0, 1'b0, 4'h7));
        wr(`SCC_OFF_CTL, 32'h0);
        wr(`SCC_OFF_CFG, cfgv(1'b1, 1'b0, 4'h7));
        #3;
        for (int i = 7; i >= 0; i--) begin
            tb_mo = 8'hc3 >> i;
            tb_clk = 1'b1;
            #40 tb_clk = 1'b0;
            #40;
        end
        tb_mo = 1'b0;
        @(posedge hclk);
        wait_done();
        rdr(`SCC_OFF_RXH);
        chk("slave_rx", 32'hc3, rd & 32'hff);
        summarize();
    end
endmodule
`default_nettype wire
